// *** src/udr_regs.svh ***
// register offsets, field positions, reset values and timing counts of the dual-role control block
`ifndef UDR_REGS_SVH
`define UDR_REGS_SVH

// ==========================================
// byte offsets on the register bus
`define UDR_OFS_POWER 5'h00
`define UDR_OFS_STATUS 5'h04
`define UDR_OFS_CONTROL 5'h08
`define UDR_OFS_ADDRESS 5'h0C
`define UDR_OFS_DUAL_ROLE 5'h10

// ==========================================
// power control fields
`define UDR_PWR_POWER_ON 0
`define UDR_PWR_SUSPEND 1
`define UDR_PWR_GUARD 4
`define UDR_PWR_ACT_PEND 7

// ==========================================
// last transfer status fields
`define UDR_STAT_ODD 2
`define UDR_STAT_DIR 3
`define UDR_STAT_EP_LSB 4
`define UDR_STAT_EP_MSB 7

// ==========================================
// control fields, both views
`define UDR_CTL_ATTACH 0
`define UDR_CTL_SOF_EN 0
`define UDR_CTL_PP_CLEAR 1
`define UDR_CTL_RESUME 2
`define UDR_CTL_HOST 3
`define UDR_CTL_BUS_RESET 4
`define UDR_CTL_HALT 5
`define UDR_CTL_TOKEN_BUSY 5
`define UDR_CTL_SE0 6
`define UDR_CTL_JSTATE 7

// ==========================================
// address and dual-role fields
`define UDR_ADR_LSB 0
`define UDR_ADR_MSB 6
`define UDR_ADR_LOW_SPEED 7
`define UDR_DRL_ENABLE 2
`define UDR_DRL_DM_PULLDOWN 4
`define UDR_DRL_DP_PULLDOWN 5
`define UDR_DRL_DM_PULLUP 6
`define UDR_DRL_DP_PULLUP 7

// ==========================================
// reset values and timing
`define UDR_RST_BYTE 8'h00
`define UDR_RST_EP 4'h0
`define UDR_RST_ADDR 7'h00
`define UDR_CLK_KHZ 25000
`define UDR_SOF_PERIOD_US 1000
`define UDR_SOF_PERIOD_CYC ((`UDR_SOF_PERIOD_US * `UDR_CLK_KHZ) / 1000)

`endif

// *** src/udr_pkg.sv ***
// types shared by the dual-role control block
package udr_pkg;
    typedef logic [7:0] udr_byte_t;
    typedef logic [3:0] udr_endpoint_t;
    typedef enum logic {
        UDR_VIEW_DEVICE = 1'b0,
        UDR_VIEW_HOST = 1'b1
    } udr_view_t;
endpackage : udr_pkg

// *** src/udr_control.sv ***
// control and status registers of the dual-role serial interface engine, avalon-mm slave
// How it works
// - power-on bit enables module when set, disables when clear except halt, pointer clear, low speed and address outputs; resets zero.
// - suspend request set gates usb clock and puts transceiver in low power.
// - guard bit warns of imminent suspend; cleared guard means no suspend coming.
// - activity pending is read-only; with guard set it shows suspension is unsafe.
// - each completed transfer loads the 4-bit endpoint number it updated.
// - direction bit reads 1 for transmit, 0 for receive of last transaction.
// - bank bit reads 1 for odd descriptor bank, 0 for even bank.
// - live single-ended-zero flag readable in both modes.
// - device mode halt bit stops token processing; setup token sets it.
// - host capability enables host operation and both data-line pull-downs.
// - device mode attach bit enables module and the d-plus pull-up.
// - writing 1 to pointer clear returns all ping-pong pointers to even bank.
// - host mode live j-state flag; differential 0 low speed, 1 full speed.
// - host mode token busy bit is high while a token executes.
// - host mode bus reset drives while its bit is set; software times 50 ms.
// - resume signalling drives while resume bit is set; software times 10 ms.
// - host mode frame marker enable sends a start-of-frame token every 1 ms.
// - host mode low-speed select; in device mode it reads zero.
// - writable 7-bit device address in the low bits, reset zero.
// - dual-role enable hands pull resistors to software, else host and attach decide.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "udr_regs.svh"

module udr_control import udr_pkg::*; #(
    parameter int SOF_PERIOD_CYCLES = `UDR_SOF_PERIOD_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_xfer_done,
    input wire logic [3:0] i_xfer_endpoint,
    input wire logic i_xfer_tx,
    input wire logic i_xfer_odd,
    input wire logic i_setup_token,
    input wire logic i_token_active,
    input wire logic i_bus_active,
    input wire logic i_line_se0,
    input wire logic i_line_diff,
    output logic o_module_enable,
    output logic o_suspend,
    output logic o_packet_halt,
    output logic o_host_mode,
    output logic o_dp_pullup,
    output logic o_dm_pullup,
    output logic o_dp_pulldown,
    output logic o_dm_pulldown,
    output logic o_bus_reset,
    output logic o_resume,
    output logic o_pingpong_clear,
    output logic o_sof_tick,
    output logic o_low_speed,
    output logic [6:0] o_device_address
);
    localparam int SOF_W = $clog2(SOF_PERIOD_CYCLES);

    // the frame counter needs at least one count before it wraps
    if (SOF_PERIOD_CYCLES < 2) begin : g_bad_period
        $error("SOF_PERIOD_CYCLES must be at least 2");
    end

    // ==========================================
    // software-visible state
    logic pwr_on_ff, susp_req_ff, guard_ff, act_pend_ff;
    udr_endpoint_t stat_ep_ff;
    logic stat_dir_ff, stat_odd_ff;
    logic halt_ff, attach_ff, sof_en_ff, bus_reset_ff, resume_ff, ppclr_ff;
    udr_view_t view_ff;
    logic low_speed_ff;
    logic [6:0] dev_addr_ff;
    logic drole_ff;
    logic sw_dp_up_ff, sw_dm_up_ff, sw_dp_dn_ff, sw_dm_dn_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic module_en_ff, suspend_ff, halt_out_ff, host_out_ff;
    logic dp_up_ff, dm_up_ff, dp_dn_ff, dm_dn_ff;
    logic bus_reset_out_ff, resume_out_ff, ppclr_pulse_ff, sof_tick_ff, low_speed_out_ff;
    logic [6:0] dev_addr_out_ff;

    // ==========================================
    // line synchronisers
    logic [1:0] line_in;
    logic [1:0] sync1_ff, sync2_ff, sync3_ff, line_ff;
    assign line_in = {i_line_diff, i_line_se0};

    // one process for both lines, so every stage has a single driver
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
            sync3_ff <= 2'h0;
            line_ff <= 2'h0;
        end else begin
            sync1_ff <= line_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            // a change counts only once two stages agree
            for (int b = 0; b < 2; b++) begin
                if (sync2_ff[b] == sync3_ff[b]) begin
                    line_ff[b] <= sync3_ff[b];
                end
            end
        end
    end

    logic se0_live, jstate_live, is_host;
    assign is_host = (view_ff == UDR_VIEW_HOST);
    assign se0_live = line_ff[0];
    assign jstate_live = low_speed_ff ? ~line_ff[1] : line_ff[1];

    // ==========================================
    // bus slave: one wait cycle, then completion
    logic wr_fire, rd_fire;
    udr_byte_t wd;
    assign wr_fire = i_avs_write && !wait_ff && i_avs_byteenable[0];
    assign rd_fire = i_avs_read && wait_ff;
    assign wd = i_avs_writedata[7:0];

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wait_ff <= 1'b1;
        end else if ((i_avs_read || i_avs_write) && wait_ff) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    udr_byte_t nxt_rbyte;
    always_comb begin
        nxt_rbyte = `UDR_RST_BYTE;
        unique case (i_avs_address)
            `UDR_OFS_POWER: begin
                nxt_rbyte[`UDR_PWR_POWER_ON] = pwr_on_ff;
                nxt_rbyte[`UDR_PWR_SUSPEND] = susp_req_ff;
                nxt_rbyte[`UDR_PWR_GUARD] = guard_ff;
                nxt_rbyte[`UDR_PWR_ACT_PEND] = act_pend_ff;
            end
            `UDR_OFS_STATUS: begin
                nxt_rbyte[`UDR_STAT_EP_MSB:`UDR_STAT_EP_LSB] = stat_ep_ff;
                nxt_rbyte[`UDR_STAT_DIR] = stat_dir_ff;
                nxt_rbyte[`UDR_STAT_ODD] = stat_odd_ff;
            end
            `UDR_OFS_CONTROL: begin
                nxt_rbyte[`UDR_CTL_SE0] = se0_live;
                nxt_rbyte[`UDR_CTL_HOST] = is_host;
                nxt_rbyte[`UDR_CTL_RESUME] = resume_ff;
                nxt_rbyte[`UDR_CTL_PP_CLEAR] = ppclr_ff;
                if (is_host) begin
                    nxt_rbyte[`UDR_CTL_JSTATE] = jstate_live;
                    nxt_rbyte[`UDR_CTL_TOKEN_BUSY] = i_token_active;
                    nxt_rbyte[`UDR_CTL_BUS_RESET] = bus_reset_ff;
                    nxt_rbyte[`UDR_CTL_SOF_EN] = sof_en_ff;
                end else begin
                    nxt_rbyte[`UDR_CTL_HALT] = halt_ff;
                    nxt_rbyte[`UDR_CTL_ATTACH] = attach_ff;
                end
            end
            `UDR_OFS_ADDRESS: begin
                nxt_rbyte[`UDR_ADR_MSB:`UDR_ADR_LSB] = dev_addr_ff;
                nxt_rbyte[`UDR_ADR_LOW_SPEED] = is_host && low_speed_ff;
            end
            `UDR_OFS_DUAL_ROLE: begin
                nxt_rbyte[`UDR_DRL_ENABLE] = drole_ff;
                nxt_rbyte[`UDR_DRL_DP_PULLUP] = sw_dp_up_ff;
                nxt_rbyte[`UDR_DRL_DM_PULLUP] = sw_dm_up_ff;
                nxt_rbyte[`UDR_DRL_DP_PULLDOWN] = sw_dp_dn_ff;
                nxt_rbyte[`UDR_DRL_DM_PULLDOWN] = sw_dm_dn_ff;
            end
            default: nxt_rbyte = `UDR_RST_BYTE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_fire) begin
            rdata_ff <= {24'h00_0000, nxt_rbyte};
        end
    end

    logic wr_pwr, wr_ctl, wr_adr, wr_drl;
    assign wr_pwr = wr_fire && (i_avs_address == `UDR_OFS_POWER);
    assign wr_ctl = wr_fire && (i_avs_address == `UDR_OFS_CONTROL);
    assign wr_adr = wr_fire && (i_avs_address == `UDR_OFS_ADDRESS);
    assign wr_drl = wr_fire && (i_avs_address == `UDR_OFS_DUAL_ROLE);

    // ==========================================
    // power control
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pwr_on_ff <= 1'b0;
            guard_ff <= 1'b0;
        end else if (wr_pwr) begin
            pwr_on_ff <= wd[`UDR_PWR_POWER_ON];
            guard_ff <= wd[`UDR_PWR_GUARD];
        end
    end

    // bus activity wakes the module; a software set in the same cycle wins
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            susp_req_ff <= 1'b0;
        end else if (wr_pwr) begin
            susp_req_ff <= wd[`UDR_PWR_SUSPEND];
        end else if (i_bus_active) begin
            susp_req_ff <= 1'b0;
        end
    end

    // only meaningful with the guard up; otherwise reads as safe
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            act_pend_ff <= 1'b0;
        end else begin
            act_pend_ff <= guard_ff && (i_bus_active || i_token_active || i_xfer_done);
        end
    end

    // ==========================================
    // last transfer status
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stat_ep_ff <= `UDR_RST_EP;
            stat_dir_ff <= 1'b0;
            stat_odd_ff <= 1'b0;
        end else if (i_xfer_done) begin
            stat_ep_ff <= i_xfer_endpoint;
            stat_dir_ff <= i_xfer_tx;
            stat_odd_ff <= i_xfer_odd;
        end
    end

    // ==========================================
    // control register, view chosen by host capability
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            view_ff <= UDR_VIEW_DEVICE;
            resume_ff <= 1'b0;
            ppclr_ff <= 1'b0;
            attach_ff <= 1'b0;
            sof_en_ff <= 1'b0;
            bus_reset_ff <= 1'b0;
        end else if (wr_ctl) begin
            view_ff <= udr_view_t'(wd[`UDR_CTL_HOST]);
            resume_ff <= wd[`UDR_CTL_RESUME];
            ppclr_ff <= wd[`UDR_CTL_PP_CLEAR];
            if (is_host) begin
                sof_en_ff <= wd[`UDR_CTL_SOF_EN];
                bus_reset_ff <= wd[`UDR_CTL_BUS_RESET];
            end else begin
                attach_ff <= wd[`UDR_CTL_ATTACH];
            end
        end
    end

    // hardware set from a setup token beats a software clear
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            halt_ff <= 1'b0;
        end else if (i_setup_token && !is_host) begin
            halt_ff <= 1'b1;
        end else if (wr_ctl && !is_host) begin
            halt_ff <= wd[`UDR_CTL_HALT];
        end
    end

    // ==========================================
    // address and dual-role control
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dev_addr_ff <= `UDR_RST_ADDR;
            low_speed_ff <= 1'b0;
        end else if (wr_adr) begin
            dev_addr_ff <= wd[`UDR_ADR_MSB:`UDR_ADR_LSB];
            low_speed_ff <= wd[`UDR_ADR_LOW_SPEED];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            drole_ff <= 1'b0;
            sw_dp_up_ff <= 1'b0;
            sw_dm_up_ff <= 1'b0;
            sw_dp_dn_ff <= 1'b0;
            sw_dm_dn_ff <= 1'b0;
        end else if (wr_drl) begin
            drole_ff <= wd[`UDR_DRL_ENABLE];
            sw_dp_up_ff <= wd[`UDR_DRL_DP_PULLUP];
            sw_dm_up_ff <= wd[`UDR_DRL_DM_PULLUP];
            sw_dp_dn_ff <= wd[`UDR_DRL_DP_PULLDOWN];
            sw_dm_dn_ff <= wd[`UDR_DRL_DM_PULLDOWN];
        end
    end

    // ==========================================
    // start-of-frame timer; cleared while suspended since the usb clock is gated
    logic [SOF_W-1:0] sof_cnt_ff;
    logic sof_run;
    assign sof_run = pwr_on_ff && is_host && sof_en_ff && !susp_req_ff;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sof_cnt_ff <= '0;
            sof_tick_ff <= 1'b0;
        end else if (!sof_run) begin
            sof_cnt_ff <= '0;
            sof_tick_ff <= 1'b0;
        end else if (sof_cnt_ff == SOF_W'(SOF_PERIOD_CYCLES - 1)) begin
            sof_cnt_ff <= '0;
            sof_tick_ff <= 1'b1;
        end else begin
            sof_cnt_ff <= sof_cnt_ff + SOF_W'(1);
            sof_tick_ff <= 1'b0;
        end
    end

    // ==========================================
    // registered outputs; halt, pointer clear, low speed and address are not gated by module power
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            module_en_ff <= 1'b0;
            suspend_ff <= 1'b0;
            halt_out_ff <= 1'b0;
            host_out_ff <= 1'b0;
            bus_reset_out_ff <= 1'b0;
            resume_out_ff <= 1'b0;
            ppclr_pulse_ff <= 1'b0;
            low_speed_out_ff <= 1'b0;
            dev_addr_out_ff <= `UDR_RST_ADDR;
        end else begin
            module_en_ff <= pwr_on_ff && (is_host || attach_ff);
            suspend_ff <= pwr_on_ff && susp_req_ff;
            halt_out_ff <= halt_ff && !is_host;
            host_out_ff <= pwr_on_ff && is_host;
            bus_reset_out_ff <= pwr_on_ff && is_host && bus_reset_ff;
            resume_out_ff <= pwr_on_ff && resume_ff;
            ppclr_pulse_ff <= wr_ctl && wd[`UDR_CTL_PP_CLEAR];
            low_speed_out_ff <= is_host && low_speed_ff;
            dev_addr_out_ff <= dev_addr_ff;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dp_up_ff <= 1'b0;
            dm_up_ff <= 1'b0;
            dp_dn_ff <= 1'b0;
            dm_dn_ff <= 1'b0;
        end else if (!pwr_on_ff) begin
            dp_up_ff <= 1'b0;
            dm_up_ff <= 1'b0;
            dp_dn_ff <= 1'b0;
            dm_dn_ff <= 1'b0;
        end else if (drole_ff) begin
            dp_up_ff <= sw_dp_up_ff;
            dm_up_ff <= sw_dm_up_ff;
            dp_dn_ff <= sw_dp_dn_ff;
            dm_dn_ff <= sw_dm_dn_ff;
        end else begin
            dp_up_ff <= attach_ff && !is_host;
            dm_up_ff <= 1'b0;
            dp_dn_ff <= is_host;
            dm_dn_ff <= is_host;
        end
    end

    assign o_avs_readdata = rdata_ff;
    assign o_avs_waitrequest = wait_ff;
    assign o_module_enable = module_en_ff;
    assign o_suspend = suspend_ff;
    assign o_packet_halt = halt_out_ff;
    assign o_host_mode = host_out_ff;
    assign o_dp_pullup = dp_up_ff;
    assign o_dm_pullup = dm_up_ff;
    assign o_dp_pulldown = dp_dn_ff;
    assign o_dm_pulldown = dm_dn_ff;
    assign o_bus_reset = bus_reset_out_ff;
    assign o_resume = resume_out_ff;
    assign o_pingpong_clear = ppclr_pulse_ff;
    assign o_sof_tick = sof_tick_ff;
    assign o_low_speed = low_speed_out_ff;
    assign o_device_address = dev_addr_out_ff;

    // ==========================================
    // assertions
    sequence s_req_waiting;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_one_wait_then_idle;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    AST_BUS_ONE_WAIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_req_waiting |=> s_one_wait_then_idle) else $error("bus answer not after one wait cycle");
    AST_POWER_GATES: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !pwr_on_ff |=> !o_module_enable && !o_suspend && !o_bus_reset) else $error("outputs live with power off");
    AST_SUSPEND: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (pwr_on_ff && susp_req_ff) |=> o_suspend) else $error("suspend not applied");
    AST_ACT_PEND_GUARD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (guard_ff && i_bus_active) |=> act_pend_ff ##1 (act_pend_ff || !guard_ff || !$past(i_bus_active)))
        else $error("activity pending wrong under guard");
    AST_NO_GUARD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !guard_ff |=> !act_pend_ff) else $error("activity pending set without guard");
    AST_STATUS_LOAD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_xfer_done |=> (stat_ep_ff == $past(i_xfer_endpoint)) && (stat_dir_ff == $past(i_xfer_tx))
        && (stat_odd_ff == $past(i_xfer_odd))) else $error("status not loaded from transfer");
    AST_SETUP_HALT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (i_setup_token && !is_host) |=> ##1 o_packet_halt) else $error("setup token did not halt");
    AST_HOST_PULLDOWN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (pwr_on_ff && is_host && !drole_ff) |=> o_dp_pulldown && o_dm_pulldown && !o_dp_pullup)
        else $error("host pull-downs missing");
    AST_ATTACH_PULLUP: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        (pwr_on_ff && !is_host && !drole_ff && attach_ff) |=> o_dp_pullup && !o_dp_pulldown)
        else $error("attach pull-up missing");
    AST_PP_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_pingpong_clear |-> $past(wr_ctl) && $past(wd[`UDR_CTL_PP_CLEAR]))
        else $error("pointer clear without write");
    AST_SOF_OFF: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !sof_run |=> !o_sof_tick) else $error("frame marker while disabled");
    AST_SOF_SPACING: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_sof_tick |-> sof_cnt_ff == '0 ##1 !o_sof_tick) else $error("frame marker spacing wrong");
    AST_LOW_SPEED_DEV: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !is_host |=> !o_low_speed) else $error("low speed in device mode");
endmodule : udr_control

// *** sim/udr_engine_model.sv ***
// far-side engine model: transfer completions, setup tokens and live line states
`timescale 1ns/1ns
module udr_engine_model (
    input wire logic i_clk,
    output logic o_done,
    output logic [3:0] o_ep,
    output logic o_tx,
    output logic o_odd,
    output logic o_setup,
    output logic o_tok,
    output logic o_act,
    output logic o_se0,
    output logic o_diff
);
    initial begin
        {o_done, o_ep, o_tx, o_odd, o_setup, o_tok, o_act, o_se0, o_diff} = '0;
    end
    // qualifiers are only held for the strobe cycle, then turned over so stale values cannot pass
    task automatic xfer(input logic [3:0] ep, input logic tx, input logic odd);
        @(posedge i_clk);
        {o_done, o_ep, o_tx, o_odd} <= {1'b1, ep, tx, odd};
        @(posedge i_clk);
        {o_done, o_ep, o_tx, o_odd} <= {1'b0, ~ep, ~tx, ~odd};
    endtask : xfer
    task automatic setup();
        @(posedge i_clk);
        o_setup <= 1'b1;
        @(posedge i_clk);
        o_setup <= 1'b0;
    endtask : setup
    task automatic lines(input logic [3:0] v);
        @(posedge i_clk);
        {o_tok, o_act, o_se0, o_diff} <= v;
    endtask : lines
endmodule : udr_engine_model

// *** sim/udr_control_test.sv ***
// self-checking bench of the dual-role control block
`timescale 1ns/1ns
module udr_control_test;
    logic clk = 0, rst_b = 0, rd_s = 0, wr_s = 0;
    logic [4:0] adr = '0;
    logic [31:0] wd = '0, rdat;
    logic wq, done, tx, odd, stp, tok, act, se0, dif;
    logic [3:0] ep;
    logic [6:0] dadr;
    logic [12:0] o;
    logic [3:0] be = 4'hF;
    logic [23:0] q[$];
    logic [23:0] n;
    int err_total = 0, tests_run = 0, seed = 32'h6415, pp_n = 0, sof_n = 0, s0;
    logic [3:0] e;
    initial begin
        forever #20 clk = ~clk;
    end
    udr_control #(.SOF_PERIOD_CYCLES(10)) dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_avs_address(adr),
        .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_xfer_done(done), .i_xfer_endpoint(ep),
        .i_xfer_tx(tx), .i_xfer_odd(odd), .i_setup_token(stp), .i_token_active(tok), .i_bus_active(act),
        .i_line_se0(se0), .i_line_diff(dif), .o_module_enable(o[0]), .o_suspend(o[1]),
        .o_packet_halt(o[2]), .o_host_mode(o[3]), .o_dp_pullup(o[4]), .o_dm_pullup(o[5]),
        .o_dp_pulldown(o[6]), .o_dm_pulldown(o[7]), .o_bus_reset(o[8]), .o_resume(o[9]),
        .o_pingpong_clear(o[10]), .o_sof_tick(o[11]), .o_low_speed(o[12]), .o_device_address(dadr));
    udr_engine_model eng (.i_clk(clk), .o_done(done), .o_ep(ep), .o_tx(tx), .o_odd(odd), .o_setup(stp),
        .o_tok(tok), .o_act(act), .o_se0(se0), .o_diff(dif));
    // ==========================================
    // checking
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        tests_run++;
        if (got !== ex) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, ex, got);
        end
    endtask : chk
    always @(posedge clk) begin
        pp_n += int'(o[10] === 1'b1);
        sof_n += int'(o[11] === 1'b1);
        if (rd_s && wq === 1'b0 && q.size() > 0) begin
            n = q.pop_front();
            chk($sformatf("reg %h", n[20:16]), n[7:0], rdat[7:0] & n[15:8]);
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // ==========================================
    // register bus
    task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd <= {24'h0, d};
        rd_s <= !w;
        wr_s <= w;
        @(posedge clk);
        while (wq !== 1'b0) begin
            @(posedge clk);
        end
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] x);
        q.push_back({3'b0, a, m, x & m});
        bus(a, 1'b0, 8'h00);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(a, 1'b1, d);
        repeat (4) @(posedge clk);
    endtask : wr
    // ==========================================
    // scenarios
    initial begin
        #400000 err_total++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) rd(5'(i * 4), 8'hFF, 8'h00);
        dadr_chk: begin
            e = 4'($random(seed));
            wr(5'h0C, {1'b1, e, 3'h5});
            rd(5'h0C, 8'hFF, {1'b0, e, 3'h5});
            chk("addr", {1'b0, e, 3'h5}, {1'b0, dadr});
            be <= 4'hE;
            wr(5'h0C, 8'h7A);
            be <= 4'hF;
            rd(5'h0C, 8'hFF, {1'b0, e, 3'h5});
        end
        wr(5'h0C, 8'h00);
        wr(5'h00, 8'h01);
        chk("enable", 0, o[0]);
        wr(5'h08, 8'h01);
        chk("enable", 1, {o[0], o[4]} == 2'b11);
        wr(5'h00, 8'h03);
        chk("suspend", 1, o[1]);
        wr(5'h00, 8'h11);
        eng.lines(4'b0100);
        rd(5'h00, 8'hFF, 8'h91);
        eng.lines(4'b0000);
        repeat (3) @(posedge clk);
        rd(5'h00, 8'hFF, 8'h11);
        for (int k = 0; k < 4; k++) begin
            e = k == 0 ? 4'hF : k == 1 ? 4'h0 : 4'($random(seed));
            eng.xfer(e, k[0], k[1]);
            rd(5'h04, 8'hFF, {e, k[0], k[1], 2'b00});
        end
        eng.lines(4'b0010);
        repeat (6) @(posedge clk);
        rd(5'h08, 8'h40, 8'h40);
        eng.setup();
        repeat (4) @(posedge clk);
        chk("halt", 1, o[2]);
        rd(5'h08, 8'h20, 8'h20);
        wr(5'h08, 8'h03);
        chk("ppclr", 1, {o[2], 7'(pp_n)});
        wr(5'h08, 8'h08);
        chk("host", 8'hC9, o[7:0]);
        s0 = sof_n;
        wr(5'h08, 8'h1D);
        repeat (51) @(posedge clk);
        chk("sof", 5, 8'(sof_n - s0));
        chk("rst_res", 3, o[9:8]);
        wr(5'h08, 8'h08);
        s0 = sof_n;
        repeat (30) @(posedge clk);
        chk("sof_off", 0, 8'(sof_n - s0));
        eng.lines(4'b1001);
        repeat (6) @(posedge clk);
        rd(5'h08, 8'hE0, 8'hA0);
        wr(5'h0C, 8'h80);
        chk("lowspd", 1, o[12]);
        rd(5'h08, 8'h80, 8'h00);
        wr(5'h10, 8'h44);
        chk("dmpu", 1, o[5]);
        wr(5'h10, 8'h00);
        wr(5'h08, 8'h00);
        wr(5'h00, 8'h00);
        chk("off", 0, o[7:0]);
        results();
    end
endmodule : udr_control_test
